/* File: core/vlcc_pkg.sv */
// Purpose: Shared constants and carriers for the rail level control block
// Assumes: 10-bit rail ADC codes, 50 MHz system clock
// Notes: Limit tables exist for both builds; the top selects one by parameter
package vlcc_pkg;
    localparam int VLCC_REQ_W = 3;
    localparam int VLCC_SEL_W = 4;
    localparam int VLCC_ADC_W = 10;
    localparam int VLCC_MEM_AW = 5;
    localparam int VLCC_MEM_DEPTH = 32;
    localparam int VLCC_MAX_PDO = 6;
    // Requested-voltage codes
    localparam logic [2:0] VLCC_REQ_0V = 3'h0;
    localparam logic [2:0] VLCC_REQ_5V = 3'h1;
    localparam logic [2:0] VLCC_REQ_9V = 3'h2;
    localparam logic [2:0] VLCC_REQ_12V = 3'h3;
    localparam logic [2:0] VLCC_REQ_19V = 3'h4;
    // One-hot regulator select patterns
    localparam logic [3:0] VLCC_SEL_0V = 4'h0;
    localparam logic [3:0] VLCC_SEL_5V = 4'h1;
    localparam logic [3:0] VLCC_SEL_9V = 4'h2;
    localparam logic [3:0] VLCC_SEL_12V = 4'h4;
    localparam logic [3:0] VLCC_SEL_19V = 4'h8;
    // One ADC count is about 25.16129 mV; recharacterise for other ranges
    localparam logic [9:0] VLCC_ZERO = 10'h000;
    localparam logic [9:0] DRP_0P5V = 10'd83;
    localparam logic [9:0] DRP_4P75V = 10'd231;
    localparam logic [9:0] DRP_5P5V = 10'd258;
    localparam logic [9:0] DRP_8P55V = 10'd364;
    localparam logic [9:0] DRP_9P7V = 10'd402;
    localparam logic [9:0] DRP_11P4V = 10'd470;
    localparam logic [9:0] DRP_12P85V = 10'd508;
    localparam logic [9:0] DRP_18P05V = 10'd740;
    localparam logic [9:0] CHG_0P5V = 10'd25;
    localparam logic [9:0] CHG_4P75V = 10'd170;
    localparam logic [9:0] CHG_5P5V = 10'd215;
    localparam logic [9:0] CHG_8P55V = 10'd320;
    localparam logic [9:0] CHG_9P7V = 10'd375;
    localparam logic [9:0] CHG_11P4V = 10'd433;
    localparam logic [9:0] CHG_12P85V = 10'd492;
    localparam logic [9:0] CHG_18P05V = 10'd716;
    // Capabilities memory map
    localparam logic [4:0] VLCC_SRC_PDO_ADDR = 5'h10;
    localparam logic [4:0] VLCC_SNK_PDO_ADDR = 5'h17;
    localparam logic [4:0] VLCC_PDO_CNT_ADDR = 5'h19;
    localparam logic [4:0] VLCC_PARTNER_ADDR = 5'h00;
    // Fixed-supply source PDO fields
    localparam int PDO_TYPE_HI = 31;
    localparam int PDO_TYPE_LO = 30;
    localparam int PDO_DRP_BIT = 29;
    localparam int PDO_SUSP_BIT = 28;
    localparam int PDO_EXT_BIT = 27;
    localparam int PDO_COMM_BIT = 26;
    localparam int PDO_DRSWAP_BIT = 25;
    localparam int PDO_PEAK_HI = 21;
    localparam int PDO_PEAK_LO = 20;
    localparam int PDO_VOLT_HI = 19;
    localparam int PDO_VOLT_LO = 10;
    localparam int PDO_CURR_HI = 9;
    localparam int PDO_CURR_LO = 0;
    localparam logic [1:0] PDO_TYPE_FIXED = 2'h0;
    // Default images
    localparam logic [31:0] DRP_SRC_PDO0 = 32'h2A01_905A;
    localparam logic [31:0] DRP_SNK_PDO0 = 32'h2A01_905A;
    localparam logic [31:0] DRP_PDO_CNT = 32'h2200_0021;
    localparam logic [31:0] CHG_SRC_PDO0 = 32'h2A01_905A;
    localparam logic [31:0] CHG_SRC_PDO1 = 32'h2A01_912C;
    localparam logic [31:0] CHG_SRC_PDO2 = 32'h2A01_90C8;
    localparam logic [31:0] CHG_SRC_PDO3 = 32'h2A01_90A0;
    localparam logic [31:0] CHG_SRC_PDO4 = 32'h2A01_9064;
    localparam logic [31:0] CHG_PDO_CNT = 32'h0000_0005;
    // Register port map (word addresses)
    localparam logic [7:0] VLCC_REG_CTRL = 8'h00;
    localparam logic [7:0] VLCC_REG_STAT = 8'h01;
    localparam logic [7:0] VLCC_REG_IRQ = 8'h02;
    localparam logic [7:0] VLCC_REG_MASK = 8'h03;
    localparam logic [7:0] VLCC_REG_MEM_BASE = 8'h40;
    localparam int CTRL_SEL_LSB = 1;
    localparam logic [3:0] VLCC_MASK_RST = 4'h0;
    // Interrupt status bit positions
    localparam int IRQ_REQ = 0;
    localparam int IRQ_REACHED = 1;
    localparam int IRQ_DISCH_DONE = 2;
    localparam int IRQ_FAULT = 3;

    typedef enum logic [1:0] {
        VLCC_IDLE = 2'b00,
        VLCC_RAMP = 2'b01,
        VLCC_STABLE = 2'b10,
        VLCC_DISCH = 2'b11
    } vlcc_state_e;

    typedef struct packed {
        logic [9:0] lower;
        logic [9:0] upper;
    } vlcc_limits_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } vlcc_bus_req_s;
endpackage

/* File: core/vlcc_rail_ctrl.sv */
// Purpose: Rail level control and capabilities memory of a Type-C power port
// Assumes: Rail samples and requests are synchronous to i_clk
// Notes: Build choice is by parameter; both limit tables are carried
// Operation
// - Requested voltage is a 3-bit code: 0,5,9,12,19 V as 0..4.
// - Regulator select is one-hot: 0000,0001,0010,0100,1000.
// - Lower limit per request: 4.75,8.55,11.4,18.05 V, otherwise zero.
// - Upper limit per request: 0.5,5.5,9.7,12.85 V, otherwise zero.
// - Limits are ADC codes of about 25.16129 mV per count.
// - Dual-role build limits are codes 83,231,258,364,402,470,508,740.
// - Charger build limits are codes 25,170,215,320,375,433,492,716.
// - Without regulation, leave selection to host and interrupt it on requests.
// - Enable the rail output when cable detect commands it.
// - During a transition drive the level the policy manager selects.
// - Watch the rail for reaching the level; manage discharge on lowering.
// - Memory holds default source objects, a dual-role default sink object, plus partner sink space.
// - Memory words are 32 bits, loaded from an image at power-on.
// - Source objects at 10h, sink objects at 17h, count at 19h.
// - At most six power objects are supported.
// - Charger build default image holds five power objects.
// - Fixed source object: type 31:30, flags at bits 29 down to 25.
// - Bits 24:22 reserved, 21:20 peak, 19:10 voltage, 9:0 current.
`timescale 1ns/1ns
module vlcc_rail_ctrl #(
    parameter bit CHARGER_BUILD = 1'b0,
    parameter bit REGULATION_EN = 1'b1
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_rail_enable_cmd,
    input wire logic [vlcc_pkg::VLCC_REQ_W-1:0] i_voltage_request_level,
    input wire logic i_transition_req,
    input wire logic [vlcc_pkg::VLCC_ADC_W-1:0] i_rail_sample,
    input wire logic i_sample_valid,
    input wire vlcc_pkg::vlcc_bus_req_s i_bus,
    output logic [31:0] o_rdata,
    output logic o_rail_on,
    output logic [vlcc_pkg::VLCC_SEL_W-1:0] o_regulator_select_pattern,
    output logic o_discharge_en,
    output logic o_level_reached,
    output logic o_irq
);
    import vlcc_pkg::*;

    vlcc_state_e state_ff;
    vlcc_state_e nxt_state;
    logic [2:0] req_ff;
    logic [3:0] sel_ff;
    logic rail_on_ff;
    logic disch_ff;
    logic reached_ff;
    logic [3:0] irq_stat_ff;
    logic [3:0] mask_ff;
    logic [3:0] host_sel_ff;
    logic irq_ff;
    logic [31:0] rdata_ff;
    typedef logic [31:0] vlcc_image_t [VLCC_MEM_DEPTH];

    // Power-on image; a declaration initialiser keeps the write process the only driver
    function automatic vlcc_image_t vlcc_boot_image();
        vlcc_image_t img;
        for (int i = 0; i < VLCC_MEM_DEPTH; i++) begin
            img[i] = 32'h0000_0000;
        end
        // Default words use the fixed-supply object layout
        if (CHARGER_BUILD) begin
            img[VLCC_SRC_PDO_ADDR] = CHG_SRC_PDO0;
            img[VLCC_SRC_PDO_ADDR + 5'h1] = CHG_SRC_PDO1;
            img[VLCC_SRC_PDO_ADDR + 5'h2] = CHG_SRC_PDO2;
            img[VLCC_SRC_PDO_ADDR + 5'h3] = CHG_SRC_PDO3;
            img[VLCC_SRC_PDO_ADDR + 5'h4] = CHG_SRC_PDO4;
            img[VLCC_PDO_CNT_ADDR] = CHG_PDO_CNT;
        end else begin
            img[VLCC_SRC_PDO_ADDR] = DRP_SRC_PDO0;
            img[VLCC_SNK_PDO_ADDR] = DRP_SNK_PDO0;
            img[VLCC_PDO_CNT_ADDR] = DRP_PDO_CNT;
        end
        return img;
    endfunction

    vlcc_image_t caps_mem = vlcc_boot_image();
    vlcc_limits_s lim;
    logic in_window;
    logic below_zero;
    logic [3:0] sel_decode;
    logic [3:0] events;
    logic mem_hit;
    logic [4:0] mem_idx;

    // Limit selection per build and request
    always_comb begin
        lim.lower = VLCC_ZERO;
        lim.upper = VLCC_ZERO;
        case (req_ff)
            VLCC_REQ_0V: begin
                lim.upper = CHARGER_BUILD ? CHG_0P5V : DRP_0P5V;
            end
            VLCC_REQ_5V: begin
                lim.lower = CHARGER_BUILD ? CHG_4P75V : DRP_4P75V;
                lim.upper = CHARGER_BUILD ? CHG_5P5V : DRP_5P5V;
            end
            VLCC_REQ_9V: begin
                lim.lower = CHARGER_BUILD ? CHG_8P55V : DRP_8P55V;
                lim.upper = CHARGER_BUILD ? CHG_9P7V : DRP_9P7V;
            end
            VLCC_REQ_12V: begin
                lim.lower = CHARGER_BUILD ? CHG_11P4V : DRP_11P4V;
                lim.upper = CHARGER_BUILD ? CHG_12P85V : DRP_12P85V;
            end
            VLCC_REQ_19V: begin
                // No upper bound is checked at the top level
                lim.lower = CHARGER_BUILD ? CHG_18P05V : DRP_18P05V;
            end
            default: begin
                lim.lower = VLCC_ZERO;
            end
        endcase
    end

    // Request code to one-hot pattern
    always_comb begin
        case (req_ff)
            VLCC_REQ_0V: sel_decode = VLCC_SEL_0V;
            VLCC_REQ_5V: sel_decode = VLCC_SEL_5V;
            VLCC_REQ_9V: sel_decode = VLCC_SEL_9V;
            VLCC_REQ_12V: sel_decode = VLCC_SEL_12V;
            VLCC_REQ_19V: sel_decode = VLCC_SEL_19V;
            default: sel_decode = VLCC_SEL_0V;
        endcase
    end

    // Window check on the live sample
    assign in_window = (i_rail_sample >= lim.lower) &&
        ((lim.upper == VLCC_ZERO) || (i_rail_sample <= lim.upper));
    assign below_zero = i_rail_sample < (CHARGER_BUILD ? CHG_0P5V : DRP_0P5V);

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            req_ff <= VLCC_REQ_0V;
        end else if (i_transition_req) begin
            req_ff <= i_voltage_request_level;
        end
    end

    // Transition sequencer
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            VLCC_IDLE: begin
                if (i_rail_enable_cmd) begin
                    nxt_state = VLCC_RAMP;
                end
            end
            VLCC_RAMP: begin
                if (!i_rail_enable_cmd) begin
                    nxt_state = VLCC_DISCH;
                end else if (i_transition_req) begin
                    nxt_state = VLCC_RAMP;
                end else if (i_sample_valid && in_window) begin
                    nxt_state = VLCC_STABLE;
                end
            end
            VLCC_STABLE: begin
                if (!i_rail_enable_cmd) begin
                    nxt_state = VLCC_DISCH;
                end else if (i_transition_req) begin
                    nxt_state = (i_voltage_request_level < req_ff) ? VLCC_DISCH : VLCC_RAMP;
                end
            end
            VLCC_DISCH: begin
                if (i_sample_valid && (i_rail_enable_cmd ? in_window : below_zero)) begin
                    nxt_state = i_rail_enable_cmd ? VLCC_STABLE : VLCC_IDLE;
                end
            end
            default: nxt_state = VLCC_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_ff <= VLCC_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Rail enable follows cable detect
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rail_on_ff <= 1'b0;
        end else begin
            rail_on_ff <= i_rail_enable_cmd;
        end
    end

    // Host drives the select when regulation is off
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            sel_ff <= VLCC_SEL_0V;
        end else if (!i_rail_enable_cmd) begin
            sel_ff <= VLCC_SEL_0V;
        end else begin
            sel_ff <= REGULATION_EN ? sel_decode : host_sel_ff;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            disch_ff <= 1'b0;
            reached_ff <= 1'b0;
        end else begin
            disch_ff <= REGULATION_EN && (nxt_state == VLCC_DISCH);
            reached_ff <= REGULATION_EN && (nxt_state == VLCC_STABLE);
        end
    end

    // Capabilities memory with power-on image
    assign mem_hit = (i_bus.addr >= VLCC_REG_MEM_BASE) &&
        (i_bus.addr < VLCC_REG_MEM_BASE + 8'(VLCC_MEM_DEPTH));
    assign mem_idx = i_bus.addr[4:0];

    // Partner sink objects live below 10h; source slot 16h, past the sixth object, is not writable
    always_ff @(posedge i_clk) begin
        if (i_bus.wr && mem_hit &&
            !((mem_idx >= VLCC_SRC_PDO_ADDR + 5'(VLCC_MAX_PDO)) && (mem_idx < VLCC_SNK_PDO_ADDR))) begin
            caps_mem[mem_idx] <= i_bus.wdata;
        end
    end

    // Register port
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            mask_ff <= VLCC_MASK_RST;
            host_sel_ff <= VLCC_SEL_0V;
        end else if (i_bus.wr && i_bus.addr == VLCC_REG_MASK) begin
            mask_ff <= i_bus.wdata[3:0];
        end else if (i_bus.wr && i_bus.addr == VLCC_REG_CTRL) begin
            host_sel_ff <= i_bus.wdata[CTRL_SEL_LSB +: 4];
        end
    end

    assign events[IRQ_REQ] = i_transition_req;
    assign events[IRQ_REACHED] = (nxt_state == VLCC_STABLE) && (state_ff != VLCC_STABLE);
    assign events[IRQ_DISCH_DONE] = (state_ff == VLCC_DISCH) && (nxt_state == VLCC_IDLE);
    assign events[IRQ_FAULT] = (state_ff == VLCC_STABLE) && i_sample_valid && !in_window;

    // Set wins over the read-clear in the same cycle
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            irq_stat_ff <= 4'h0;
        end else if (i_bus.rd && i_bus.addr == VLCC_REG_IRQ) begin
            irq_stat_ff <= events;
        end else begin
            irq_stat_ff <= irq_stat_ff | events;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(nxt_irq_stat() & mask_ff);
        end
    end

    function automatic logic [3:0] nxt_irq_stat();
        if (i_bus.rd && i_bus.addr == VLCC_REG_IRQ) begin
            return events;
        end
        return irq_stat_ff | events;
    endfunction

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rdata_ff <= 32'h0000_0000;
        end else if (i_bus.rd) begin
            if (mem_hit) begin
                rdata_ff <= caps_mem[mem_idx];
            end else begin
                case (i_bus.addr)
                    VLCC_REG_CTRL: rdata_ff <= {27'h0, host_sel_ff, 1'b0};
                    VLCC_REG_STAT: rdata_ff <= {16'h0, 2'(state_ff), req_ff, 1'b0, i_rail_sample};
                    VLCC_REG_IRQ: rdata_ff <= {28'h0, irq_stat_ff};
                    VLCC_REG_MASK: rdata_ff <= {28'h0, mask_ff};
                    default: rdata_ff <= 32'h0000_0000;
                endcase
            end
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end

    assign o_rdata = rdata_ff;
    assign o_rail_on = rail_on_ff;
    assign o_regulator_select_pattern = sel_ff;
    assign o_discharge_en = disch_ff;
    assign o_level_reached = reached_ff;
    assign o_irq = irq_ff;

    property p_sel_onehot;
        @(posedge i_clk) disable iff (i_reset)
        $onehot0(o_regulator_select_pattern);
    endproperty
    a_sel_onehot: assert property (p_sel_onehot) else $error("select not one-hot");

    property p_sel_follows;
        @(posedge i_clk) disable iff (i_reset)
        (REGULATION_EN && i_rail_enable_cmd && req_ff == VLCC_REQ_9V) |=>
            o_regulator_select_pattern == VLCC_SEL_9V;
    endproperty
    a_sel_follows: assert property (p_sel_follows) else $error("9 V pattern wrong");

    property p_lower_5v;
        @(posedge i_clk) disable iff (i_reset)
        req_ff == VLCC_REQ_5V |-> lim.lower == (CHARGER_BUILD ? CHG_4P75V : DRP_4P75V);
    endproperty
    a_lower_5v: assert property (p_lower_5v) else $error("5 V lower limit wrong");

    property p_upper_19v;
        @(posedge i_clk) disable iff (i_reset)
        req_ff == VLCC_REQ_19V |-> lim.upper == VLCC_ZERO;
    endproperty
    a_upper_19v: assert property (p_upper_19v) else $error("19 V upper not zero");

    property p_rail_on;
        @(posedge i_clk) disable iff (i_reset)
        $rose(i_rail_enable_cmd) |=> o_rail_on;
    endproperty
    a_rail_on: assert property (p_rail_on) else $error("rail not enabled");

    property p_req_irq;
        @(posedge i_clk) disable iff (i_reset)
        (i_transition_req && mask_ff[IRQ_REQ]) |=> o_irq;
    endproperty
    a_req_irq: assert property (p_req_irq) else $error("no request interrupt");

    property p_reached;
        @(posedge i_clk) disable iff (i_reset)
        (REGULATION_EN && state_ff == VLCC_RAMP && i_rail_enable_cmd && !i_transition_req
            && i_sample_valid && in_window) |=> o_level_reached;
    endproperty
    a_reached: assert property (p_reached) else $error("level not flagged");

    property p_disch_off;
        @(posedge i_clk) disable iff (i_reset)
        (REGULATION_EN && state_ff == VLCC_STABLE && !i_rail_enable_cmd) |=> o_discharge_en;
    endproperty
    a_disch_off: assert property (p_disch_off) else $error("no discharge");

    property p_disch_end;
        @(posedge i_clk) disable iff (i_reset)
        (state_ff == VLCC_DISCH && !i_rail_enable_cmd && i_sample_valid && below_zero)
            |=> !o_discharge_en;
    endproperty
    a_disch_end: assert property (p_disch_end) else $error("discharge not ended");

    property p_sel_off;
        @(posedge i_clk) disable iff (i_reset)
        !i_rail_enable_cmd |=> o_regulator_select_pattern == VLCC_SEL_0V;
    endproperty
    a_sel_off: assert property (p_sel_off) else $error("select live with rail off");

    property p_rail_off;
        @(posedge i_clk) disable iff (i_reset)
        !i_rail_enable_cmd |=> !o_rail_on;
    endproperty
    a_rail_off: assert property (p_rail_off) else $error("rail left on");

    property p_host_sel;
        @(posedge i_clk) disable iff (i_reset)
        (!REGULATION_EN && i_rail_enable_cmd) |=>
            o_regulator_select_pattern == $past(host_sel_ff);
    endproperty
    a_host_sel: assert property (p_host_sel) else $error("host select not applied");
endmodule

/* File: verif/vbus_level_control_caps_memory_tb_top.sv */
// Purpose: Self-checking bench for the rail level control block
// Assumes: Dual-role build under test, charger build without regulation beside it
// Notes: Both instances share inputs, so bus reads clear both status registers
`timescale 1ns/1ns
module vbus_level_control_caps_memory_tb_top;
    import vlcc_pkg::*;
    logic i_clk, i_reset, rail_en, treq, slow, force_en, valid;
    logic rail_on, dis, reached, irq, irq2;
    logic [2:0] code;
    logic [9:0] sample, force_val;
    logic [3:0] sel, sel2;
    logic [7:0] a;
    logic [31:0] rdata, rdata2, d, d2, v, keep;
    vlcc_bus_req_s bus;
    int bad_count = 0;
    int tests_run = 0;

    vlcc_rail_ctrl dut (.i_clk(i_clk), .i_reset(i_reset), .i_rail_enable_cmd(rail_en),
        .i_voltage_request_level(code), .i_transition_req(treq), .i_rail_sample(sample),
        .i_sample_valid(valid), .i_bus(bus), .o_rdata(rdata), .o_rail_on(rail_on),
        .o_regulator_select_pattern(sel), .o_discharge_en(dis), .o_level_reached(reached),
        .o_irq(irq));
    vlcc_rail_ctrl #(.CHARGER_BUILD(1'b1), .REGULATION_EN(1'b0)) dut2 (.i_clk(i_clk),
        .i_reset(i_reset), .i_rail_enable_cmd(rail_en), .i_voltage_request_level(code),
        .i_transition_req(treq), .i_rail_sample(sample), .i_sample_valid(valid),
        .i_bus(bus), .o_rdata(rdata2), .o_rail_on(), .o_regulator_select_pattern(sel2),
        .o_discharge_en(), .o_level_reached(), .o_irq(irq2));
    vlcc_rail_model model (.i_clk(i_clk), .i_reset(i_reset), .i_select(sel),
        .i_discharge_en(dis), .i_slow(slow), .i_force_en(force_en), .i_force_val(force_val),
        .o_rail_sample(sample), .o_sample_valid(valid));

    function automatic logic [3:0] onehot(input logic [2:0] c);
        return (c == 3'd0) ? 4'b0000 : 4'b0001 << (c - 3'd1);
    endfunction
    function automatic logic [9:0] lower(input logic [2:0] c);
        case (c)
            3'd1: return 10'd231;
            3'd2: return 10'd364;
            3'd3: return 10'd470;
            3'd4: return 10'd740;
            default: return 10'd0;
        endcase
    endfunction
    function automatic logic [9:0] upper(input logic [2:0] c);
        case (c)
            3'd0: return 10'd83;
            3'd1: return 10'd258;
            3'd2: return 10'd402;
            3'd3: return 10'd508;
            default: return 10'd0;
        endcase
    endfunction

    task automatic wrap_up();
        if (bad_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] val);
        @(posedge i_clk);
        bus <= '{addr: ad, wdata: val, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        bus.wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so they are taken there
    task automatic rd(input logic [7:0] ad);
        @(posedge i_clk);
        bus <= '{addr: ad, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        bus.rd <= 1'b0;
        #1;
        d = rdata;
        d2 = rdata2;
    endtask
    task automatic request(input logic [2:0] c);
        @(posedge i_clk);
        code <= c;
        treq <= 1'b1;
        @(posedge i_clk);
        treq <= 1'b0;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wait_for(input int k, input logic [3:0] val, input int n);
        logic hit;
        hit = 1'b0;
        tests_run++;
        for (int i = 0; i < n && !hit; i++) begin
            step(1);
            case (k)
                0: hit = (sel === val);
                1: hit = (reached === val[0]);
                2: hit = (dis === val[0]);
                default: hit = (rail_on === val[0]);
            endcase
        end
        if (!hit) begin
            bad_count++;
            $display("CHECK FAILED wait %0d expected %h seen timeout", k, val);
            wrap_up();
        end
    endtask

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    initial begin
        i_reset = 1'b1;
        {rail_en, treq, slow, force_en} = 4'h0;
        code = 3'd0;
        force_val = 10'd0;
        bus = '{addr: 8'h00, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b0};
        void'($urandom(32'had4c));
        repeat (10) @(posedge i_clk);
        i_reset <= 1'b0;
        rd(VLCC_REG_MASK);
        chk("mask reset", 32'h0000_0000, d);
        rd(VLCC_REG_MEM_BASE + 8'h10);
        chk("source object", DRP_SRC_PDO0, d);
        chk("supply type", 32'h0, {30'h0, d[31:30]});
        chk("voltage field", 32'd100, {22'h0, d[19:10]});
        rd(VLCC_REG_MEM_BASE + 8'h17);
        chk("sink object", DRP_SNK_PDO0, d);
        rd(VLCC_REG_MEM_BASE + 8'h19);
        chk("object count", DRP_PDO_CNT, d);
        chk("charger count", 32'h0000_0005, d2);
        rd(VLCC_REG_MEM_BASE + 8'h16);
        keep = d;
        wr(VLCC_REG_MEM_BASE + 8'h16, ~keep);
        rd(VLCC_REG_MEM_BASE + 8'h16);
        chk("slot past six", keep, d);
        rd(8'h20);
        chk("unmapped", 32'h0000_0000, d);
        repeat (4) begin
            a = VLCC_REG_MEM_BASE + 8'($urandom_range(0, 15));
            v = $urandom;
            wr(a, v);
            rd(a);
            chk("partner space", v, d);
        end
        // Window edges first, with the sample pinned
        wr(VLCC_REG_MASK, 32'h0000_000F);
        rail_en <= 1'b1;
        wait_for(3, 4'h1, 4);
        force_en <= 1'b1;
        force_val <= lower(3'd1) - 10'd1;
        request(VLCC_REQ_5V);
        wait_for(0, onehot(3'd1), 4);
        step(6);
        chk("below lower", 32'h0, {31'h0, reached});
        chk("request irq", 32'h1, {31'h0, irq});
        rd(VLCC_REG_IRQ);
        chk("request status", 32'h1, d);
        force_val <= lower(3'd1);
        wait_for(1, 4'h1, 4);
        force_val <= upper(3'd1);
        step(4);
        chk("at upper", 32'h1, {31'h0, reached});
        wr(VLCC_REG_MASK, 32'h0000_0007);
        rd(VLCC_REG_IRQ);
        chk("reached status", 32'h2, d);
        force_val <= upper(3'd1) + 10'd1;
        step(4);
        chk("masked irq", 32'h0, {31'h0, irq});
        rd(VLCC_REG_IRQ);
        chk("window fault", 32'h8, d & 32'h0000_0008);
        // Charger instance is still ramping at 5 V; its window starts at code 170
        force_val <= 10'd169;
        step(4);
        rd(VLCC_REG_STAT);
        chk("charger under window", {30'h0, VLCC_RAMP}, {30'h0, d2[15:14]});
        force_val <= 10'd170;
        step(4);
        rd(VLCC_REG_STAT);
        chk("charger at lower", {30'h0, VLCC_STABLE}, {30'h0, d2[15:14]});
        force_en <= 1'b0;
        wr(VLCC_REG_MASK, 32'h0000_000F);
        step(4);
        rd(VLCC_REG_IRQ);
        // Rising steps through every remaining code, at random sample rate
        for (int c = 2; c <= 4; c++) begin
            slow <= 1'($urandom_range(0, 1));
            request(3'(c));
            wait_for(0, onehot(3'(c)), 4);
            chk("no early reach", 32'h0, {31'h0, reached});
            wait_for(1, 4'h1, 400);
            chk("level irq", 32'h1, {31'h0, irq});
            rd(VLCC_REG_IRQ);
            chk("transition status", 32'h3, d);
        end
        request(VLCC_REQ_5V);
        wait_for(2, 4'h1, 4);
        wr(VLCC_REG_CTRL, 32'h0000_0008);
        step(2);
        chk("host select", 32'h4, {28'h0, sel2});
        chk("host irq", 32'h1, {31'h0, irq2});
        rail_en <= 1'b0;
        wait_for(3, 4'h0, 4);
        wait_for(0, 4'h0, 4);
        wait_for(2, 4'h1, 4);
        wait_for(2, 4'h0, 400);
        rd(VLCC_REG_IRQ);
        chk("discharge done", 32'h4, d & 32'h0000_0004);
        wrap_up();
    end
endmodule

/* File: verif/vlcc_rail_model.sv */
// Purpose: Behavioural rail ADC and regulator on the far side of the rail controller
// Assumes: Dual-role limit codes, rail moves 8 counts per cycle
// Notes: Force inputs pin the sample at window edges; slow mode gives one sample in four
`timescale 1ns/1ns
module vlcc_rail_model (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [3:0] i_select,
    input wire logic i_discharge_en,
    input wire logic i_slow,
    input wire logic i_force_en,
    input wire logic [9:0] i_force_val,
    output logic [9:0] o_rail_sample,
    output logic o_sample_valid
);
    logic [9:0] level_ff;
    logic [9:0] target;
    logic [1:0] div_ff;
    // Settled levels sit inside each window, at about 25.16129 mV a count
    always_comb begin
        case (i_select)
            4'h1: target = 10'd245;
            4'h2: target = 10'd383;
            4'h4: target = 10'd489;
            4'h8: target = 10'd800;
            default: target = i_discharge_en ? 10'd0 : level_ff;
        endcase
    end
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            level_ff <= 10'd0;
            div_ff <= 2'd0;
        end else begin
            div_ff <= div_ff + 2'd1;
            if (level_ff + 10'd8 < target) begin
                level_ff <= level_ff + 10'd8;
            end else if (level_ff > target + 10'd8) begin
                level_ff <= level_ff - 10'd8;
            end else begin
                level_ff <= target;
            end
        end
    end
    assign o_sample_valid = i_force_en | !i_slow | (div_ff == 2'd0);
    // An unqualified sample shows garbage, so a design that ignores valid is caught
    assign o_rail_sample = i_force_en ? i_force_val : (o_sample_valid ? level_ff : ~level_ff);
endmodule
